// *** logic/plc_defs.svh ***
`ifndef PLC_DEFS_SVH
`define PLC_DEFS_SVH

// register offsets on the byte-wide register port
`define PLC_OFS_GAIN      8'h07
`define PLC_OFS_PULSE     8'h08
`define PLC_OFS_INTEG     8'h09
`define PLC_OFS_PERSIST   8'h0B
`define PLC_OFS_LLOW_LSB  8'h0C
`define PLC_OFS_LLOW_MSB  8'h0D
`define PLC_OFS_LHIGH_LSB 8'h0E
`define PLC_OFS_LHIGH_MSB 8'h0F
`define PLC_OFS_PLOW_LSB  8'h10
`define PLC_OFS_PLOW_MSB  8'h11

// reset values
`define PLC_RST_BYTE      8'h00
`define PLC_RST_GAIN      2'h0
`define PLC_RST_INTEG     4'h0
`define PLC_RST_LOW_THR   16'h0000
`define PLC_RST_HIGH_THR  16'hFFFF

// field positions
`define PLC_GAIN_MSB      1
`define PLC_INTEG_MSB     3
`define PLC_PRS_LIGHT_MSB 3
`define PLC_PRS_LIGHT_LSB 0
`define PLC_PRS_PROX_MSB  7
`define PLC_PRS_PROX_LSB  4

// gain multipliers per code
`define PLC_GAIN_X1       4'h1
`define PLC_GAIN_X2       4'h2
`define PLC_GAIN_X4       4'h4
`define PLC_GAIN_X8       4'h8

// timing, times in ns, clock in MHz
`define PLC_CLK_MHZ       50
`define PLC_LED_UNIT_NS   13675
`define PLC_SLOT_GAP_NS   23680
`define PLC_BASE_NS       3051000
`define PLC_INTEG_UNIT_NS 510000
// least times round up to whole cycles
`define PLC_NS2CYC(t)     (((t) * `PLC_CLK_MHZ + 999) / 1000)
`define PLC_LED_UNIT_CYC  `PLC_NS2CYC(`PLC_LED_UNIT_NS)
`define PLC_SLOT_GAP_CYC  `PLC_NS2CYC(`PLC_SLOT_GAP_NS)
`define PLC_BASE_CYC      `PLC_NS2CYC(`PLC_BASE_NS)
`define PLC_INTEG_CYC     `PLC_NS2CYC(`PLC_INTEG_UNIT_NS)
// sub-conversions accumulated per proximity conversion
`define PLC_SUB_CONV_LAST 4'hF
`define PLC_PROX_RES_STEP 12'h100

`endif

// *** logic/plc_pkg.sv ***
package plc_pkg;

  // measurement sequencer phases
  typedef enum logic [2:0] {
    PLC_IDLE     = 3'b000,
    PLC_LIGHT    = 3'b001,
    PLC_PS_BASE  = 3'b010,
    PLC_PS_ON    = 3'b011,
    PLC_PS_GAP   = 3'b100,
    PLC_PS_INTEG = 3'b101,
    PLC_WAIT     = 3'b110
  } plc_phase_e;

  typedef logic [3:0] plc_persist_t;

endpackage

// *** logic/plc_persist.sv ***
`timescale 1ns/100ps
`include "plc_defs.svh"

module plc_persist
  import plc_pkg::*;
(
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic         conv_done,
  input  wire logic         meets,
  input  wire plc_persist_t persist,
  output logic              fire
);

  plc_persist_t count_r;

  // consecutive event counter; a miss restarts the run
  always_ff @(posedge clk) begin
    if (rst) begin
      count_r <= '0;
      fire    <= 1'b0;
    end else begin
      fire <= 1'b0;
      if (conv_done) begin
        if (persist == '0) begin
          fire    <= 1'b1;
          count_r <= '0;
        end else if (meets) begin
          if (count_r + 4'h1 == persist) begin
            fire    <= 1'b1;
            count_r <= '0;
          end else begin
            count_r <= count_r + 4'h1;
          end
        end else begin
          count_r <= '0;
        end
      end
    end
  end

endmodule

// *** logic/plc_config_regs.sv ***
`timescale 1ns/100ps
`include "plc_defs.svh"

// Function
// - two-bit proximity gain in bits 1:0, codes x1/x2/x4/x8, upper bits zero.
// - four-bit integration field; code N gives 256*(N+1)-1 maximum count.
// - proximity conversion is sixteen times base plus pulse plus integration terms.
// - full cycle is light conversion, proximity conversion, then wait time.
// - persistence bits 3:0 give consecutive light events before interrupt.
// - persistence bits 7:4 give consecutive proximity events before interrupt.
// - sixteen-bit light low threshold, low byte first, reset zero.
// - sixteen-bit light high threshold at 0x0E/0x0F, reset all ones.
// - sixteen-bit proximity low threshold at 0x10/0x11, reset zero.
// - LED pulse lasts code plus one units of 13.675 us.
// - zero persistence ignores thresholds; every conversion meets the condition.
module plc_config_regs
  import plc_pkg::*;
#(
  parameter int CW            = 24,
  parameter int BASE_CYC      = `PLC_BASE_CYC,
  parameter int INTEG_CYC     = `PLC_INTEG_CYC,
  parameter int WAIT_UNIT_CYC = 1000
) (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic [7:0]  reg_addr,
  input  wire logic        reg_wr,
  input  wire logic [7:0]  reg_wdata,
  input  wire logic        reg_rd,
  output logic      [7:0]  reg_rdata,
  input  wire logic        meas_enable,
  input  wire logic        light_conv_done,
  input  wire logic        light_source_sel,
  input  wire logic [15:0] light_ch0_result,
  input  wire logic [15:0] light_ch1_result,
  input  wire logic [15:0] proximity_result,
  input  wire logic [15:0] proximity_high_thr,
  input  wire logic [5:0]  led_pulse_width,
  input  wire logic [7:0]  wait_time_units,
  output logic             led_drive,
  output logic             cycle_start,
  output logic             prox_conv_done,
  output logic             light_int_evt,
  output logic             prox_int_evt,
  output logic      [3:0]  prox_gain_mult,
  output logic      [11:0] prox_max_count
);

  logic [1:0]   proximity_gain_select_r;
  logic [7:0]   led_pulse_count_r;
  logic [3:0]   proximity_integration_steps_r;
  logic [7:0]   persistence_r;
  logic [15:0]  light_low_thr_r;
  logic [15:0]  light_high_thr_r;
  logic [15:0]  proximity_low_thr_r;
  plc_phase_e   phase_r;
  logic [CW-1:0] tmr_r;
  logic [8:0]   slot_r;
  logic [3:0]   rep_r;
  logic [CW-1:0] on_cyc;
  logic [CW-1:0] integ_cyc;
  logic [CW-1:0] wait_cyc;
  logic         last_slot;
  logic         sub_done;
  logic [15:0]  light_sel;
  logic         light_meets;
  logic         prox_meets;
  logic         light_fire;
  logic         prox_fire;

  // register writes; reserved bits are never stored
  always_ff @(posedge clk) begin
    if (rst) begin
      proximity_gain_select_r       <= `PLC_RST_GAIN;
      led_pulse_count_r             <= `PLC_RST_BYTE;
      proximity_integration_steps_r <= `PLC_RST_INTEG;
      persistence_r                 <= `PLC_RST_BYTE;
      light_low_thr_r               <= `PLC_RST_LOW_THR;
      light_high_thr_r              <= `PLC_RST_HIGH_THR;
      proximity_low_thr_r           <= `PLC_RST_LOW_THR;
    end else if (reg_wr) begin
      case (reg_addr)
        `PLC_OFS_GAIN:      proximity_gain_select_r <= reg_wdata[`PLC_GAIN_MSB:0];
        `PLC_OFS_PULSE:     led_pulse_count_r <= reg_wdata;
        `PLC_OFS_INTEG:     proximity_integration_steps_r <= reg_wdata[`PLC_INTEG_MSB:0];
        `PLC_OFS_PERSIST:   persistence_r <= reg_wdata;
        `PLC_OFS_LLOW_LSB:  light_low_thr_r[7:0] <= reg_wdata;
        `PLC_OFS_LLOW_MSB:  light_low_thr_r[15:8] <= reg_wdata;
        `PLC_OFS_LHIGH_LSB: light_high_thr_r[7:0] <= reg_wdata;
        `PLC_OFS_LHIGH_MSB: light_high_thr_r[15:8] <= reg_wdata;
        `PLC_OFS_PLOW_LSB:  proximity_low_thr_r[7:0] <= reg_wdata;
        `PLC_OFS_PLOW_MSB:  proximity_low_thr_r[15:8] <= reg_wdata;
        default: ;
      endcase
    end
  end

  // read data lands one cycle after the strobe and holds until the next read;
  // a read and a write to one byte in the same cycle return the old value,
  // since both act on the same edge and the read sees the stored byte
  always_ff @(posedge clk) begin
    if (rst) begin
      reg_rdata <= `PLC_RST_BYTE;
    end else if (reg_rd) begin
      case (reg_addr)
        `PLC_OFS_GAIN:      reg_rdata <= {6'h00, proximity_gain_select_r};
        `PLC_OFS_PULSE:     reg_rdata <= led_pulse_count_r;
        `PLC_OFS_INTEG:     reg_rdata <= {4'h0, proximity_integration_steps_r};
        `PLC_OFS_PERSIST:   reg_rdata <= persistence_r;
        `PLC_OFS_LLOW_LSB:  reg_rdata <= light_low_thr_r[7:0];
        `PLC_OFS_LLOW_MSB:  reg_rdata <= light_low_thr_r[15:8];
        `PLC_OFS_LHIGH_LSB: reg_rdata <= light_high_thr_r[7:0];
        `PLC_OFS_LHIGH_MSB: reg_rdata <= light_high_thr_r[15:8];
        `PLC_OFS_PLOW_LSB:  reg_rdata <= proximity_low_thr_r[7:0];
        `PLC_OFS_PLOW_MSB:  reg_rdata <= proximity_low_thr_r[15:8];
        default:            reg_rdata <= `PLC_RST_BYTE; // unmapped reads zero
      endcase
    end
  end

  // gain and resolution decode, registered so outputs come from flops
  always_ff @(posedge clk) begin
    if (rst) begin
      prox_gain_mult <= `PLC_GAIN_X1;
      prox_max_count <= `PLC_PROX_RES_STEP - 12'h001;
    end else begin
      case (proximity_gain_select_r)
        2'h0:    prox_gain_mult <= `PLC_GAIN_X1;
        2'h1:    prox_gain_mult <= `PLC_GAIN_X2;
        2'h2:    prox_gain_mult <= `PLC_GAIN_X4;
        default: prox_gain_mult <= `PLC_GAIN_X8;
      endcase
      // 256*(N+1)-1, reaches 4095 at code 0xF without wrapping
      prox_max_count <= {proximity_integration_steps_r, 8'hFF};
    end
  end

  // phase lengths; widths held to the timer so no product can overflow silently
  // the widest led product, 64 units, needs far fewer bits than CW gives;
  // the long integration term at code 15 and full clock rate is what sets the timer width
  // (code+1) led units
  assign on_cyc    = CW'((CW'(led_pulse_width) + CW'(1)) * CW'(`PLC_LED_UNIT_CYC));
  assign integ_cyc = CW'(CW'(proximity_integration_steps_r) * CW'(INTEG_CYC));
  assign wait_cyc  = CW'((CW'(wait_time_units) + CW'(1)) * CW'(WAIT_UNIT_CYC));
  assign last_slot = (slot_r == {led_pulse_count_r, 1'b0});
  assign sub_done  = (tmr_r == '0) &&
                     ((phase_r == PLC_PS_INTEG) ||
                      (phase_r == PLC_PS_GAP && last_slot &&
                       proximity_integration_steps_r == `PLC_RST_INTEG));

  // measurement sequencer; a phase ends when its down-counter reaches zero
  // timing fields are read live, not shadowed: a host that rewrites them
  // mid-conversion bends that conversion, so change them between cycles
  always_ff @(posedge clk) begin
    if (rst) begin
      phase_r        <= PLC_IDLE;
      tmr_r          <= '0;
      slot_r         <= '0;
      rep_r          <= '0;
      cycle_start    <= 1'b0;
      prox_conv_done <= 1'b0;
    end else begin
      cycle_start    <= 1'b0;
      prox_conv_done <= 1'b0;
      if (tmr_r != '0) begin
        tmr_r <= tmr_r - CW'(1);
      end
      case (phase_r)
        PLC_IDLE: begin
          if (meas_enable) begin
            phase_r     <= PLC_LIGHT;
            cycle_start <= 1'b1;
          end
        end
        PLC_LIGHT: begin
          if (light_conv_done) begin
            phase_r <= PLC_PS_BASE;
            rep_r   <= '0;
            tmr_r   <= CW'(BASE_CYC - 1);
          end
        end
        PLC_PS_BASE: begin
          if (tmr_r == '0) begin
            phase_r <= PLC_PS_ON;
            slot_r  <= '0;
            tmr_r   <= on_cyc - CW'(1);
          end
        end
        PLC_PS_ON: begin
          if (tmr_r == '0) begin
            phase_r <= PLC_PS_GAP;
            tmr_r   <= CW'(`PLC_SLOT_GAP_CYC - 1);
          end
        end
        PLC_PS_GAP: begin
          if (tmr_r == '0) begin
            if (!last_slot) begin
              phase_r <= PLC_PS_ON;
              slot_r  <= slot_r + 9'h001;
              tmr_r   <= on_cyc - CW'(1);
            end else if (!sub_done) begin
              phase_r <= PLC_PS_INTEG;
              tmr_r   <= integ_cyc - CW'(1);
            end
          end
        end
        PLC_PS_INTEG: ;
        PLC_WAIT: begin
          if (tmr_r == '0) begin
            phase_r <= PLC_IDLE;
          end
        end
        default: phase_r <= PLC_IDLE;
      endcase
      if (sub_done) begin
        if (rep_r == `PLC_SUB_CONV_LAST) begin
          phase_r        <= PLC_WAIT;
          prox_conv_done <= 1'b1;
          tmr_r          <= wait_cyc - CW'(1);
        end else begin
          phase_r <= PLC_PS_BASE;
          rep_r   <= rep_r + 4'h1;
          tmr_r   <= CW'(BASE_CYC - 1);
        end
      end
    end
  end

  // LED lit on even slots of the first sub-conversion only, so a
  // measurement sees exactly count+1 pulses; odd slots pace the converter
  always_ff @(posedge clk) begin
    if (rst) begin
      led_drive <= 1'b0;
    end else begin
      led_drive <= (phase_r == PLC_PS_ON) && !slot_r[0] && (rep_r == '0);
    end
  end

  // threshold comparisons against the chosen data
  assign light_sel   = light_source_sel ? light_ch1_result : light_ch0_result;
  assign light_meets = (light_sel < light_low_thr_r) ||
                       (light_sel > light_high_thr_r);
  assign prox_meets  = (proximity_result < proximity_low_thr_r) ||
                       (proximity_result > proximity_high_thr);

  // only dones taken in the light phase count, so a stray pulse from the
  // converter cannot advance the light filter
  // light persistence
  plc_persist u_light_persist (
    .clk       (clk),
    .rst       (rst),
    .conv_done (light_conv_done && phase_r == PLC_LIGHT),
    .meets     (light_meets),
    .persist   (persistence_r[`PLC_PRS_LIGHT_MSB:`PLC_PRS_LIGHT_LSB]),
    .fire      (light_fire)
  );

  plc_persist u_prox_persist (
    .clk       (clk),
    .rst       (rst),
    .conv_done (prox_conv_done),
    .meets     (prox_meets),
    .persist   (persistence_r[`PLC_PRS_PROX_MSB:`PLC_PRS_PROX_LSB]),
    .fire      (prox_fire)
  );

  // event pulses out of the persistence filters; the extra flop keeps the
  // outputs straight from flip-flops at the cost of one cycle of latency
  always_ff @(posedge clk) begin
    if (rst) begin
      light_int_evt <= 1'b0;
      prox_int_evt  <= 1'b0;
    end else begin
      light_int_evt <= light_fire;
      prox_int_evt  <= prox_fire;
    end
  end

endmodule

// *** tb/plc_config_regs_asserts.sv ***
`timescale 1ns/100ps
module plc_config_regs_asserts (
  input wire logic        clk,
  input wire logic        rst,
  input wire logic [7:0]  reg_addr,
  input wire logic        reg_wr,
  input wire logic [7:0]  reg_wdata,
  input wire logic        reg_rd,
  input wire logic [7:0]  reg_rdata,
  input wire logic [5:0]  led_pulse_width,
  input wire logic        led_drive,
  input wire logic        cycle_start,
  input wire logic        prox_conv_done,
  input wire logic        prox_int_evt,
  input wire logic [3:0]  prox_gain_mult,
  input wire logic [11:0] prox_max_count
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  logic [7:0]  prs_r;
  logic [15:0] led_len_r;
  // shadow of persistence, so a zero field can be told apart
  always_ff @(posedge clk)
    if (rst) prs_r <= 8'h00;
    else if (reg_wr && reg_addr == 8'h0B) prs_r <= reg_wdata;
  // length of the current led pulse in cycles
  always_ff @(posedge clk)
    if (rst || !led_drive) led_len_r <= 16'h0000;
    else led_len_r <= led_len_r + 16'h0001;
  property p_gain;
    reg_wr && reg_addr == 8'h07 ##2 1 |-> prox_gain_mult == 4'h1 << $past(reg_wdata[1:0], 2);
  endproperty
  a_gain: assert property (p_gain) else $error("gain multiplier wrong");
  property p_integ;
    reg_wr && reg_addr == 8'h09 ##2 1 |-> prox_max_count == {$past(reg_wdata[3:0], 2), 8'hFF};
  endproperty
  a_integ: assert property (p_integ) else $error("max count wrong");
  property p_unmap;
    reg_rd && reg_addr == 8'h0A |=> reg_rdata == 8'h00;
  endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
  property p_rsvd;
    reg_rd && reg_addr == 8'h07 |=> reg_rdata[7:2] == 6'h00;
  endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved gain bits set");
  property p_prs0;
    prox_conv_done && prs_r[7:4] == 4'h0 |-> ##2 prox_int_evt;
  endproperty
  a_prs0: assert property (p_prs0) else $error("zero persistence did not fire");
  property p_pevt;
    prox_int_evt |-> $past(prox_conv_done, 2);
  endproperty
  a_pevt: assert property (p_pevt) else $error("event without conversion");
  property p_led;
    $fell(led_drive) |-> led_len_r == (16'(led_pulse_width) + 16'h0001) * 16'h02AC;
  endproperty
  a_led: assert property (p_led) else $error("led pulse length wrong");
  property p_start;
    cycle_start |=> !cycle_start [*8];
  endproperty
  a_start: assert property (p_start) else $error("cycle restarted early");
  c_led: cover property ($fell(led_drive));
  c_pevt: cover property (prox_int_evt);
  c_unmap: cover property (reg_rd && reg_addr == 8'h0A);
endmodule

bind plc_config_regs plc_config_regs_asserts u_chk (.clk(clk), .rst(rst),
  .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .led_pulse_width(led_pulse_width), .led_drive(led_drive),
  .cycle_start(cycle_start), .prox_conv_done(prox_conv_done),
  .prox_int_evt(prox_int_evt), .prox_gain_mult(prox_gain_mult),
  .prox_max_count(prox_max_count));

// *** tb/plc_frontend_model.sv ***
`timescale 1ns/100ps
// light converter stand-in: one done pulse per cycle, prompt or late
module plc_frontend_model (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic cycle_start,
  input  wire logic slow,
  output logic      light_conv_done
);
  int cnt_r;
  // a late answer keeps the sequencer waiting in its light phase
  always_ff @(posedge clk) begin
    if (rst) begin
      cnt_r           <= 0;
      light_conv_done <= 1'b0;
    end else if (cycle_start) begin
      cnt_r           <= slow ? 40 : 2;
      light_conv_done <= 1'b0;
    end else begin
      cnt_r           <= (cnt_r > 0) ? cnt_r - 1 : 0;
      light_conv_done <= (cnt_r == 1);
    end
  end
endmodule

// *** tb/plc_config_regs_tb_top.sv ***
`timescale 1ns/100ps
module plc_config_regs_tb_top;
  logic        clk = 1'b0, rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, slow = 1'b0;
  logic        meas_enable = 1'b0, light_source_sel = 1'b0, led_q = 1'b0;
  logic [7:0]  reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, q, d;
  logic [15:0] ch0 = 16'h0000, ch1 = 16'h0000, pres = 16'h0000, phigh = 16'hFFFF;
  logic [5:0]  led_pulse_width = 6'h00;
  logic [7:0]  wt = 8'h00;
  logic        led_drive, cycle_start, prox_conv_done, light_int_evt, prox_int_evt, lcd;
  logic [3:0]  prox_gain_mult;
  logic [11:0] prox_max_count;
  int          error_cnt = 0, n_compared = 0, n_led, n_levt, n_pevt, t0, t1, ts, cyc = 0, k;

  always #10 clk = ~clk;

  // short base and integration counts keep the run brief
  plc_config_regs #(.BASE_CYC(20), .INTEG_CYC(5), .WAIT_UNIT_CYC(4)) u_plc_config_regs (
    .clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .meas_enable(meas_enable),
    .light_conv_done(lcd), .light_source_sel(light_source_sel),
    .light_ch0_result(ch0), .light_ch1_result(ch1), .proximity_result(pres),
    .proximity_high_thr(phigh), .led_pulse_width(led_pulse_width),
    .wait_time_units(wt), .led_drive(led_drive), .cycle_start(cycle_start),
    .prox_conv_done(prox_conv_done), .light_int_evt(light_int_evt),
    .prox_int_evt(prox_int_evt), .prox_gain_mult(prox_gain_mult),
    .prox_max_count(prox_max_count));
  plc_frontend_model u_plc_frontend_model (.clk(clk), .rst(rst),
    .cycle_start(cycle_start), .slow(slow), .light_conv_done(lcd));

  // tallies per measurement, cleared as each cycle starts
  always @(posedge clk) begin
    cyc <= cyc + 1;
    led_q <= led_drive;
    if (lcd) t0 <= cyc;
    if (prox_conv_done) t1 <= cyc;
    if (cycle_start) ts <= cyc;
    n_led <= cycle_start ? 0 : n_led + (led_drive & ~led_q);
    n_levt <= cycle_start ? 0 : n_levt + light_int_evt;
    n_pevt <= cycle_start ? 0 : n_pevt + prox_int_evt;
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk_n(input int got, input int exp);
    n_compared++;
    if (got != exp) begin
      error_cnt++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 v = reg_rdata;
  endtask
  task automatic do_rst();
    @(posedge clk);
    rst <= 1'b1;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
  endtask
  function automatic logic [7:0] wmask(input logic [7:0] a);
    case (a)
      8'h07: return 8'h03;
      8'h09: return 8'h0F;
      8'h08, 8'h0B, 8'h0C, 8'h0D, 8'h0E, 8'h0F, 8'h10, 8'h11: return 8'hFF;
      default: return 8'h00;
    endcase
  endfunction
  // one measurement; ep is the expected count of each event
  task automatic run(input int ep, input int w);
    @(posedge clk);
    led_pulse_width <= 6'(w);
    meas_enable <= 1'b1;
    for (k = 0; k < 300 && !cycle_start; k++) @(posedge clk);
    meas_enable <= 1'b0;
    for (k = 0; k < 50000 && !prox_conv_done; k++) @(posedge clk);
    repeat (4) @(posedge clk);
    k = 16 * (20 + 684 * (w + 1) + 1184);
    // done is seen one cycle after the last sub-conversion ends
    chk_n(t1 - t0, k + 1);
    chk_n(n_led, 1);
    chk_n(n_levt, ep);
    chk_n(n_pevt, ep);
  endtask
  task automatic summarize();
    if (error_cnt == 0 && n_compared > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // a hang counts as a failure
  initial begin
    repeat (90000) @(posedge clk);
    error_cnt++;
    summarize();
  end

  initial begin
    void'($urandom(74225));
    do_rst();
    for (int a = 8'h06; a <= 8'h12; a++) begin
      rd(8'(a), q);
      chk(q, (a == 8'h0E || a == 8'h0F) ? 8'hFF : 8'h00);
    end
    // fresh random data each pass, inverted on the second, read back through the write mask
    for (int j = 0; j < 2; j++) begin
      for (int a = 8'h06; a <= 8'h12; a++) begin
        d = 8'($urandom);
        wr(8'(a), d ^ {8{j[0]}});
        rd(8'(a), q);
        chk(q, (d ^ {8{j[0]}}) & wmask(8'(a)));
      end
    end
    for (int c = 0; c < 16; c++) begin
      wr(8'h07, {6'($urandom), 2'(c)});
      wr(8'h09, {4'($urandom), 4'(c)});
      rd(8'h09, q);
      chk(q, 8'(c));
      chk(prox_gain_mult, 4'h1 << c[1:0]);
      chk(prox_max_count, 16'(256 * (c + 1) - 1));
    end
    do_rst();
    @(posedge clk);
    ch0 <= 16'($urandom);
    ch1 <= 16'($urandom);
    // wait long enough that the bench can raise enable inside it
    wt <= 8'(8 + $urandom % 32);
    pres <= 16'($urandom);
    run(1, 0);
    wr(8'h0B, 8'h22);
    wr(8'h0E, 8'h10);
    wr(8'h0F, 8'h00);
    @(posedge clk);
    light_source_sel <= 1'b1;
    ch0 <= 16'h0005;
    ch1 <= 16'h0200;
    pres <= 16'h0200;
    phigh <= 16'h0100;
    slow <= 1'b1;
    run(0, 1);
    // next cycle may start only once the programmed wait has run out
    meas_enable <= 1'b1;
    for (k = 0; k < 300 && !cycle_start; k++) @(posedge clk);
    meas_enable <= 1'b0;
    @(posedge clk);
    chk_n(ts - t1, (int'(wt) + 1) * 4 + 1);
    summarize();
  end
endmodule
